/* supply_mode_pkg.sv */
// Package with register map, field layout and types for supply mode control
package supply_mode_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 4;
  localparam logic [15:0] SUPPLY_MODE_CONTROL_ADDR = 16'hff01;
  localparam logic [15:0] LCD_POWER_ADDR = 16'hff60;
  localparam logic [3:0] SUPPLY_MODE_CONTROL_RESET = 4'h0;
  localparam logic [3:0] LCD_POWER_RESET = 4'h0;
  localparam int BIT_DOUBLER = 0;
  localparam int BIT_HALVER = 1;
  localparam int BIT_OSC_SEL = 2;
  localparam int BIT_LCD_SEL = 3;
  localparam int BIT_LCD_PWR = 0;
  localparam int SETTLE_MS = 100;
  localparam int CLK_KHZ = 125000;
  localparam int SETTLE_CYCLES = SETTLE_MS * CLK_KHZ;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_DOUBLE = 3'b010,
    MODE_HALVE = 3'b100
  } conv_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    conv_mode_t conv_mode;
    logic osc_regulator_on_converted;
    logic lcd_circuit_on_converted;
    logic lcd_drive_out;
  } supply_ctrl_t;
endpackage : supply_mode_pkg

/* conv_mode_decode.sv */
// Converter mode decode with doubler priority
`timescale 1ns/1ps
module conv_mode_decode (
  input wire logic doubler_enable_i, // Doubler control bit
  input wire logic halver_enable_i, // Halver control bit
  output supply_mode_pkg::conv_mode_t mode_o // Effective converter mode
);
  import supply_mode_pkg::*;
  always_comb begin
    if (doubler_enable_i) begin
      mode_o = MODE_DOUBLE; // see RL1 see RL2
    end else if (halver_enable_i) begin
      mode_o = MODE_HALVE; // see RL1
    end else begin
      mode_o = MODE_NORMAL; // see RL1
    end
  end
endmodule : conv_mode_decode

/* settle_timer.sv */
// Converter settling timer, reports when the derived voltage has had time
`timescale 1ns/1ps
module settle_timer #(
  parameter int CYCLES = supply_mode_pkg::SETTLE_CYCLES
) (
  input wire logic clk_i, // System clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic conv_on_i, // Converter running
  output logic settled_o // Settling time elapsed
);
  import supply_mode_pkg::*;
  typedef struct packed {
    logic [31:0] cnt;
    logic settled;
  } st_t;
  st_t s;
  st_t next_s;
  always_comb begin
    next_s = s;
    if (!conv_on_i) begin
      next_s.cnt = 32'h0;
      next_s.settled = 1'b0;
    end else if (s.cnt >= 32'(CYCLES - 1)) begin
      next_s.settled = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 32'h1;
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign settled_o = s.settled;
endmodule : settle_timer

/* supply_mode_control.sv */
// Supply mode control register block and derived supply steering
// How it works
// RL1: Doubler/halver bits pick normal, double or halve
// RL2: Doubler bit wins over halver bit
// RL3: One converted supply shared by both circuits
// RL4: Each circuit has its own source select
// RL5: Software waits settling before setting select
// RL6: Software clears select before converter off
// RL7: Select and converter cleared in separate writes
// RL8: Reset gives normal mode, plain supply
// RL9: LCD drive passes only while power bit set
// RL10: Lowest supply needs doubler on both circuits
// RL11: Doubler before raising core voltage
// RL12: No fast oscillator in halver mode
// RL13: Highest supply never doubles LCD circuit
// RL14: Doubler advised on supply drop report
// RL15: Control bits 3..0 LCD, osc, halve, double
// RL16: Reads return last written bits
// RL17: Effective mode decoded to analog circuits
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module supply_mode_control #(
  parameter int SETTLE_CYCLES_P = supply_mode_pkg::SETTLE_CYCLES
) (
  input wire logic clk_i, // System clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic [supply_mode_pkg::ADDR_W-1:0] addr_i, // Register address
  input wire logic [supply_mode_pkg::DATA_W-1:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  input wire logic lcd_drive_i, // LCD drive voltage present
  output logic [supply_mode_pkg::DATA_W-1:0] rdata_o, // Read data, next cycle
  output supply_mode_pkg::conv_mode_t conv_mode_o, // Effective converter mode
  output logic osc_regulator_on_converted_o, // Osc regulator uses converted supply
  output logic lcd_circuit_on_converted_o, // LCD circuit uses converted supply
  output logic lcd_drive_o, // Gated LCD drive to driver
  output logic converted_settled_o, // Converted supply settled
  output logic seq_error_o // Sticky: select and converter cleared together
);
  import supply_mode_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] ctrl;
    logic lcd_power_on;
    logic [DATA_W-1:0] rdata;
    supply_ctrl_t out;
    logic settled;
    logic seq_error;
    logic drive_meta;
    logic drive_sync;
  } state_t;

  state_t s;
  state_t next_s;
  reg_req_t req;
  conv_mode_t mode_dec;
  logic settled_raw;
  logic [DATA_W-1:0] ctrl_next;
  logic hit_ctrl;
  logic hit_pwr;
  logic conv_was_on;
  logic conv_goes_off;
  logic sel_goes_off;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign hit_ctrl = (req.addr == SUPPLY_MODE_CONTROL_ADDR);
  assign hit_pwr = (req.addr == LCD_POWER_ADDR);
  assign ctrl_next = (req.wr && hit_ctrl) ? req.wdata : s.ctrl;

  // Mode decodes the bits being written so the change shows one cycle after the write, with the stored bits
  conv_mode_decode u_decode (
    .doubler_enable_i(ctrl_next[BIT_DOUBLER]),
    .halver_enable_i(ctrl_next[BIT_HALVER]),
    .mode_o(mode_dec)
  );

  settle_timer #(
    .CYCLES(SETTLE_CYCLES_P)
  ) u_settle (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .conv_on_i(s.ctrl[BIT_DOUBLER] | s.ctrl[BIT_HALVER]),
    .settled_o(settled_raw)
  );

  assign conv_was_on = s.ctrl[BIT_DOUBLER] | s.ctrl[BIT_HALVER];
  assign conv_goes_off = conv_was_on & ~(wdata_i[BIT_DOUBLER] | wdata_i[BIT_HALVER]);
  assign sel_goes_off = (s.ctrl[BIT_OSC_SEL] & ~wdata_i[BIT_OSC_SEL])
                      | (s.ctrl[BIT_LCD_SEL] & ~wdata_i[BIT_LCD_SEL]);

  always_comb begin
    next_s = s;
    next_s.rdata = '0;
    if (req.wr && hit_ctrl) begin
      next_s.ctrl = req.wdata; // see RL15 see RL4
      if (conv_goes_off && sel_goes_off) begin
        next_s.seq_error = 1'b1; // see RL7
      end
    end
    if (req.wr && hit_pwr) begin
      next_s.lcd_power_on = req.wdata[BIT_LCD_PWR];
    end
    if (req.rd && hit_ctrl) begin
      next_s.rdata = s.ctrl; // see RL16
    end else if (req.rd && hit_pwr) begin
      next_s.rdata = {{(DATA_W-1){1'b0}}, s.lcd_power_on};
    end
    next_s.out.conv_mode = mode_dec; // see RL17 see RL2
    next_s.out.osc_regulator_on_converted = next_s.ctrl[BIT_OSC_SEL]; // see RL3 see RL4
    next_s.out.lcd_circuit_on_converted = next_s.ctrl[BIT_LCD_SEL]; // see RL3 see RL4
    // Drive level is asynchronous to this clock, two flops first
    next_s.drive_meta = lcd_drive_i;
    next_s.drive_sync = s.drive_meta;
    next_s.out.lcd_drive_out = s.lcd_power_on & s.drive_sync; // see RL9
    next_s.settled = settled_raw;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s.ctrl <= SUPPLY_MODE_CONTROL_RESET; // see RL8
      s.lcd_power_on <= LCD_POWER_RESET[BIT_LCD_PWR];
      s.rdata <= '0;
      s.out.conv_mode <= MODE_NORMAL; // see RL8
      s.out.osc_regulator_on_converted <= 1'b0;
      s.out.lcd_circuit_on_converted <= 1'b0;
      s.out.lcd_drive_out <= 1'b0;
      s.settled <= 1'b0;
      s.seq_error <= 1'b0;
      s.drive_meta <= 1'b0;
      s.drive_sync <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o = s.rdata;
  assign conv_mode_o = s.out.conv_mode;
  assign osc_regulator_on_converted_o = s.out.osc_regulator_on_converted;
  assign lcd_circuit_on_converted_o = s.out.lcd_circuit_on_converted;
  assign lcd_drive_o = s.out.lcd_drive_out;
  assign converted_settled_o = s.settled;
  assign seq_error_o = s.seq_error;

  property p_double_priority; // see RL2
    @(posedge clk_i) disable iff (!arst_n_i)
      s.ctrl[BIT_DOUBLER] |-> conv_mode_o == MODE_DOUBLE;
  endproperty
  a_double_priority: assert property (p_double_priority) // see RL2
    else $error("doubler bit set but mode not double");

  property p_halve_mode; // see RL1
    @(posedge clk_i) disable iff (!arst_n_i)
      (s.ctrl[BIT_HALVER] && !s.ctrl[BIT_DOUBLER]) |-> conv_mode_o == MODE_HALVE;
  endproperty
  a_halve_mode: assert property (p_halve_mode) // see RL1
    else $error("halver only but mode not halve");

  property p_normal_mode; // see RL1
    @(posedge clk_i) disable iff (!arst_n_i)
      (!s.ctrl[BIT_HALVER] && !s.ctrl[BIT_DOUBLER]) |-> conv_mode_o == MODE_NORMAL;
  endproperty
  a_normal_mode: assert property (p_normal_mode) // see RL1
    else $error("both off but mode not normal");

  property p_ctrl_write; // see RL15
    @(posedge clk_i) disable iff (!arst_n_i)
      (wr_i && addr_i == SUPPLY_MODE_CONTROL_ADDR) |=> s.ctrl == $past(wdata_i);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) // see RL15
    else $error("control write not stored");

  property p_readback; // see RL16
    @(posedge clk_i) disable iff (!arst_n_i)
      (rd_i && addr_i == SUPPLY_MODE_CONTROL_ADDR) |=> rdata_o == $past(s.ctrl);
  endproperty
  a_readback: assert property (p_readback) // see RL16
    else $error("readback differs from stored value");

  property p_selects; // see RL4
    @(posedge clk_i) disable iff (!arst_n_i)
      osc_regulator_on_converted_o == s.ctrl[BIT_OSC_SEL]
      && lcd_circuit_on_converted_o == s.ctrl[BIT_LCD_SEL];
  endproperty
  a_selects: assert property (p_selects) // see RL4
    else $error("select outputs differ from control bits");

  property p_lcd_gate; // see RL9
    @(posedge clk_i) disable iff (!arst_n_i)
      lcd_drive_o |-> $past(s.lcd_power_on);
  endproperty
  a_lcd_gate: assert property (p_lcd_gate) // see RL9
    else $error("lcd drive passed while power off");

  property p_mode_follows_write; // see RL17
    @(posedge clk_i) disable iff (!arst_n_i)
      (wr_i && addr_i == SUPPLY_MODE_CONTROL_ADDR && wdata_i[BIT_DOUBLER])
      |=> conv_mode_o == MODE_DOUBLE;
  endproperty
  a_mode_follows_write: assert property (p_mode_follows_write) // see RL17
    else $error("mode not updated on write");

  property p_osc_sel_on; // see RL4
    @(posedge clk_i) disable iff (!arst_n_i)
      (wr_i && hit_ctrl && wdata_i[BIT_OSC_SEL]) |=> osc_regulator_on_converted_o;
  endproperty
  a_osc_sel_on: assert property (p_osc_sel_on) // see RL4
    else $error("osc regulator select not set by write");

  property p_osc_sel_off; // see RL4
    @(posedge clk_i) disable iff (!arst_n_i)
      (wr_i && hit_ctrl && !wdata_i[BIT_OSC_SEL]) |=> !osc_regulator_on_converted_o;
  endproperty
  a_osc_sel_off: assert property (p_osc_sel_off) // see RL4
    else $error("osc regulator select not cleared by write");

  property p_lcd_sel_on; // see RL4
    @(posedge clk_i) disable iff (!arst_n_i)
      (wr_i && hit_ctrl && wdata_i[BIT_LCD_SEL]) |=> lcd_circuit_on_converted_o;
  endproperty
  a_lcd_sel_on: assert property (p_lcd_sel_on) // see RL4
    else $error("lcd circuit select not set by write");

  property p_lcd_sel_off; // see RL4
    @(posedge clk_i) disable iff (!arst_n_i)
      (wr_i && hit_ctrl && !wdata_i[BIT_LCD_SEL]) |=> !lcd_circuit_on_converted_o;
  endproperty
  a_lcd_sel_off: assert property (p_lcd_sel_off) // see RL4
    else $error("lcd circuit select not cleared by write");

  property p_halve_follows_write; // see RL17
    @(posedge clk_i) disable iff (!arst_n_i)
      (wr_i && hit_ctrl && !wdata_i[BIT_DOUBLER] && wdata_i[BIT_HALVER])
      |=> conv_mode_o == MODE_HALVE;
  endproperty
  a_halve_follows_write: assert property (p_halve_follows_write) // see RL17
    else $error("halve mode not updated on write");

  property p_normal_follows_write; // see RL17
    @(posedge clk_i) disable iff (!arst_n_i)
      (wr_i && hit_ctrl && !wdata_i[BIT_DOUBLER] && !wdata_i[BIT_HALVER])
      |=> conv_mode_o == MODE_NORMAL;
  endproperty
  a_normal_follows_write: assert property (p_normal_follows_write) // see RL17
    else $error("normal mode not updated on write");

  property p_mode_onehot; // see RL1
    @(posedge clk_i) disable iff (!arst_n_i)
      $onehot(conv_mode_o);
  endproperty
  a_mode_onehot: assert property (p_mode_onehot) // see RL1
    else $error("converter mode not one-hot");

  property p_ctrl_hold; // see RL16
    @(posedge clk_i) disable iff (!arst_n_i)
      !(wr_i && hit_ctrl) |=> $stable(s.ctrl);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) // see RL16
    else $error("control bits changed without a write");

  property p_rdata_idle; // see RL16
    @(posedge clk_i) disable iff (!arst_n_i)
      !rd_i |=> rdata_o == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) // see RL16
    else $error("read data not zero outside a read");

  property p_rdata_power; // see RL16
    @(posedge clk_i) disable iff (!arst_n_i)
      (rd_i && hit_pwr)
      |=> rdata_o[0] == $past(s.lcd_power_on) && rdata_o[DATA_W-1:1] == '0;
  endproperty
  a_rdata_power: assert property (p_rdata_power) // see RL16
    else $error("power readback differs from stored bit");

  property p_pwr_on; // see RL9
    @(posedge clk_i) disable iff (!arst_n_i)
      (wr_i && hit_pwr && wdata_i[BIT_LCD_PWR]) |=> s.lcd_power_on;
  endproperty
  a_pwr_on: assert property (p_pwr_on) // see RL9
    else $error("lcd power bit not set by write");

  property p_drive_off; // see RL9
    @(posedge clk_i) disable iff (!arst_n_i)
      !s.lcd_power_on |=> !lcd_drive_o;
  endproperty
  a_drive_off: assert property (p_drive_off) // see RL9
    else $error("lcd drive passed with power bit clear");

  property p_drive_sync; // see RL9
    @(posedge clk_i) disable iff (!arst_n_i)
      lcd_drive_o |-> $past(s.drive_sync);
  endproperty
  a_drive_sync: assert property (p_drive_sync) // see RL9
    else $error("lcd drive passed without drive present");

  property p_seq_error_set; // see RL7
    @(posedge clk_i) disable iff (!arst_n_i)
      (wr_i && hit_ctrl && conv_goes_off && sel_goes_off)
      |=> seq_error_o;
  endproperty
  a_seq_error_set: assert property (p_seq_error_set) // see RL7
    else $error("combined select and converter clear not flagged");

  property p_seq_error_sticky; // see RL7
    @(posedge clk_i) disable iff (!arst_n_i)
      seq_error_o |=> seq_error_o;
  endproperty
  a_seq_error_sticky: assert property (p_seq_error_sticky) // see RL7
    else $error("sequence error flag dropped");

  property p_settled_off; // see RL5
    @(posedge clk_i) disable iff (!arst_n_i)
      (!s.ctrl[BIT_DOUBLER] && !s.ctrl[BIT_HALVER])
      |-> ##2 !converted_settled_o;
  endproperty
  a_settled_off: assert property (p_settled_off) // see RL5
    else $error("settled flag high with converter off");
endmodule : supply_mode_control

/* tb_top.sv */
// Self-checking testbench for the supply mode control block
`timescale 1ns/1ps
module tb_top;
  import supply_mode_pkg::*;
  localparam int SETTLE = 16;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [3:0] wdata_i = 4'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic lcd_drive_i = 1'b0;
  logic [3:0] rdata_o;
  conv_mode_t conv_mode_o;
  logic osc_sel_o, lcd_sel_o, lcd_drive_o, settled_o, seq_error_o;
  logic [3:0] d;
  int n_fail = 0;
  int comparisons = 0;

  supply_mode_control #(.SETTLE_CYCLES_P(SETTLE)) DUT (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .lcd_drive_i(lcd_drive_i), .rdata_o(rdata_o),
    .conv_mode_o(conv_mode_o), .osc_regulator_on_converted_o(osc_sel_o),
    .lcd_circuit_on_converted_o(lcd_sel_o), .lcd_drive_o(lcd_drive_o),
    .converted_settled_o(settled_o), .seq_error_o(seq_error_o)
  );

  always #4 clk_i = ~clk_i;

  task chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task wr(input logic [15:0] a, input logic [3:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  task rd(input logic [15:0] a, output logic [3:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask : rd

  task t_reset;
    rd(SUPPLY_MODE_CONTROL_ADDR, d);
    chk("ctrl reset", d, SUPPLY_MODE_CONTROL_RESET);
    chk("mode reset", {1'b0, conv_mode_o}, {1'b0, MODE_NORMAL});
    chk("sels reset", {osc_sel_o, lcd_sel_o}, 4'h0);
    rd(LCD_POWER_ADDR, d);
    chk("power reset", d, LCD_POWER_RESET);
    $display("test reset done");
  endtask : t_reset

  task t_modes;
    conv_mode_t m;
    for (int i = 0; i < 4; i++) begin
      wr(SUPPLY_MODE_CONTROL_ADDR, 4'(i));
      m = i[0] ? MODE_DOUBLE : (i[1] ? MODE_HALVE : MODE_NORMAL);
      chk("mode", {1'b0, conv_mode_o}, {1'b0, m});
      rd(SUPPLY_MODE_CONTROL_ADDR, d);
      chk("readback", d, 4'(i));
    end
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'h0);
    $display("test modes done");
  endtask : t_modes

  task t_settle_select;
    int n;
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'h1);
    repeat (SETTLE - 6) @(posedge clk_i);
    #1;
    chk("settled early", settled_o, 1'b0);
    n = 0;
    while (settled_o !== 1'b1 && n < 12) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk("settled", settled_o, 1'b1);
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'h5);
    chk("osc only", {osc_sel_o, lcd_sel_o}, 4'h2);
    chk("shared mode", {1'b0, conv_mode_o}, {1'b0, MODE_DOUBLE});
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'h9);
    chk("lcd only", {osc_sel_o, lcd_sel_o}, 4'h1);
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'hd);
    chk("both sel", {osc_sel_o, lcd_sel_o}, 4'h3);
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'h1);
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'h0);
    chk("clean exit", seq_error_o, 1'b0);
    repeat (3) @(posedge clk_i);
    #1;
    chk("settled off", settled_o, 1'b0);
    $display("test settle and select done");
  endtask : t_settle_select

  task t_lcd;
    @(posedge clk_i);
    lcd_drive_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    chk("drive gated", lcd_drive_o, 1'b0);
    wr(LCD_POWER_ADDR, 4'h1);
    repeat (4) @(posedge clk_i);
    #1;
    chk("drive on", lcd_drive_o, 1'b1);
    rd(LCD_POWER_ADDR, d);
    chk("power rb", d, 4'h1);
    @(posedge clk_i);
    lcd_drive_i <= 1'b0;
    #1;
    chk("rdata idle", rdata_o, 4'h0);
    repeat (4) @(posedge clk_i);
    #1;
    chk("drive absent", lcd_drive_o, 1'b0);
    wr(LCD_POWER_ADDR, 4'h0);
    $display("test lcd done");
  endtask : t_lcd

  task t_unmapped_seq;
    wr(16'hff02, 4'hf);
    rd(SUPPLY_MODE_CONTROL_ADDR, d);
    chk("ctrl untouched", d, 4'h0);
    rd(16'hff02, d);
    chk("unmapped rd", d, 4'h0);
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'h5);
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'h0);
    chk("seq error", seq_error_o, 1'b1);
    $display("test unmapped and sequence done");
  endtask : t_unmapped_seq

  task t_ranges;
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'h1);
    repeat (SETTLE + 2) @(posedge clk_i);
    #1;
    chk("settled low", settled_o, 1'b1);
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'hd);
    chk("low sels", {osc_sel_o, lcd_sel_o}, 4'h3);
    chk("low mode", {1'b0, conv_mode_o}, {1'b0, MODE_DOUBLE});
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'h1);
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'h0);
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'h2);
    repeat (SETTLE + 2) @(posedge clk_i);
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'he);
    chk("high mode", {1'b0, conv_mode_o}, {1'b0, MODE_HALVE});
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'ha);
    chk("osc normal", {osc_sel_o, lcd_sel_o}, 4'h1);
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'h2);
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'h1);
    chk("drop mode", {1'b0, conv_mode_o}, {1'b0, MODE_DOUBLE});
    repeat (SETTLE + 2) @(posedge clk_i);
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'h9);
    chk("drop sels", {osc_sel_o, lcd_sel_o}, 4'h1);
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'h1);
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'h0);
    chk("ranges exit", seq_error_o, 1'b0);
    $display("test supply ranges done");
  endtask : t_ranges

  task t_midrst;
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'h1);
    repeat (SETTLE + 2) @(posedge clk_i);
    wr(SUPPLY_MODE_CONTROL_ADDR, 4'hd);
    wr(LCD_POWER_ADDR, 4'h1);
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    #1;
    chk("rst mode", {1'b0, conv_mode_o}, {1'b0, MODE_NORMAL});
    chk("rst sels", {osc_sel_o, lcd_sel_o}, 4'h0);
    chk("rst flags", {seq_error_o, settled_o}, 4'h0);
    rd(SUPPLY_MODE_CONTROL_ADDR, d);
    chk("rst ctrl", d, SUPPLY_MODE_CONTROL_RESET);
    rd(LCD_POWER_ADDR, d);
    chk("rst power", d, LCD_POWER_RESET);
    $display("test mid-run reset done");
  endtask : t_midrst

  task results;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  initial begin
    #(8 * 2000);
    n_fail++;
    results();
  end

  initial begin
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_modes();
    t_settle_select();
    t_ranges();
    t_lcd();
    t_unmapped_seq();
    t_midrst();
    results();
  end
endmodule : tb_top
